// [core/radio_test_slot_regs.v]
// Behaviour
// - Endless receive bit keeps window open
// - Endless transmit bit gives never-ending payload
// - Endless non-random payload repeats test-length pattern
// - Length source picks descriptor or test length
// - Random kind picks 9 or 15 stage
// - 9-stage generator 1+x5+x9, seeded ones
// - 15-stage generator given polynomial, seeded ones
// - Payload source picks memory or generator
// - Test length used in test mode, and as repeat length for endless memory transmit in any mode
// - Prefetch instant set in microseconds
// - Coarse interrupt on bits 19:4, low zero
// - Slot interrupt when target equals counter
// - Capture trigger samples counter, self-clears
// - Strength select: peak-hold or averaged
// - Wakeup status mirrored, auto-acknowledged after power-up
`default_nettype none
`include "radio_regs_consts.vh"

module radio_test_slot_regs #(
  parameter SLOT_CYCLES = `SLOT_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire         i_core_clk,
  input  wire         i_rst,
  // APB slave.
  input  wire         i_psel,
  input  wire         i_penable,
  input  wire         i_pwrite,
  input  wire [31:0]  i_paddr,
  input  wire [31:0]  i_pwdata,
  output reg  [31:0]  o_prdata,
  output reg          o_pready,
  output reg          o_pslverr,
  // Link-layer side.
  input  wire         i_test_mode,
  input  wire [7:0]   i_descriptor_adv_length,
  input  wire         i_payload_start,
  input  wire         i_payload_take,
  input  wire [7:0]   i_mem_byte,
  output reg  [8:0]   o_mem_index,
  output reg  [7:0]   o_payload_byte,
  output reg          o_payload_valid,
  output reg          o_payload_last,
  output reg          o_endless_receive,
  output reg          o_table_fetch,
  output reg          o_signal_strength_select,
  // Low-power domain pins.
  input  wire         i_lowpower_wakeup_interrupt,
  input  wire         i_radio_powered,
  input  wire         i_lp_clk,
  output reg          o_wakeup_ack,
  // Interrupt.
  output reg          o_irq
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;
  localparam integer CYC_PER_US = `NS_PER_US / `CLK_PERIOD_NS;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg                  endless_rx_r;
  reg                  endless_tx_r;
  reg                  payload_length_source_r;
  reg                  pseudo_random_kind_r;
  reg                  payload_source_select_r;
  reg  [`RFT_LEN_MSB:0] test_payload_length_r;
  reg  [`PREF_MSB:0]   table_prefetch_time_r;
  reg  [`COARSE_MSB:0] coarse_target_value_r;
  reg  [`CNT_MSB:0]    slot_target_value_r;
  reg                  capture_r;
  reg  [`CNT_MSB:0]    base_sample_r;
  reg                  rssi_sel_r;
  reg  [`IRQ_MSB:0]    irq_stat_r;
  reg  [`IRQ_MSB:0]    irq_mask_r;
  reg  [31:0]          rdata_nxt;
  reg                  unmapped_nxt;
  reg                  wake_s1, wake_s2, wake_d;
  reg                  pwr_s1, pwr_s2;
  reg                  lp_s1, lp_s2, lp_d;
  reg  [1:0]           lp_edges_r;

  wire [`CNT_MSB:0]    base_slot_counter;
  wire [`PRESC_MSB:0]  cycles_left;
  wire                 slot_tick;

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  wire setup_rd = i_psel && !i_penable;
  wire wr_en    = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

  always @* begin
    rdata_nxt    = `RESET_WORD;
    unmapped_nxt = 1'b0;
    case (i_paddr)
      `ADDR_RF_TEST: begin
        rdata_nxt[`RFT_RX_BIT]        = endless_rx_r;
        rdata_nxt[`RFT_TX_BIT]        = endless_tx_r;
        rdata_nxt[`RFT_LSRC_BIT]      = payload_length_source_r;
        rdata_nxt[`RFT_PTYPE_BIT]     = pseudo_random_kind_r;
        rdata_nxt[`RFT_PSRC_BIT]      = payload_source_select_r;
        rdata_nxt[`RFT_LEN_MSB:0]     = test_payload_length_r;
      end
      `ADDR_TIMING:    rdata_nxt[`PREF_MSB:0]   = table_prefetch_time_r;
      `ADDR_COARSE:    rdata_nxt[`COARSE_MSB:0] = coarse_target_value_r;
      `ADDR_SLOT:      rdata_nxt[`CNT_MSB:0]    = slot_target_value_r;
      `ADDR_SAMPLE:    rdata_nxt[`CAPT_BIT]     = capture_r;
      `ADDR_CTRL2: begin
        rdata_nxt[`RSSI_BIT] = rssi_sel_r;
        rdata_nxt[`WAKE_BIT] = wake_s2;
      end
      `ADDR_IRQ_STAT:  rdata_nxt[`IRQ_MSB:0] = irq_stat_r;
      `ADDR_IRQ_MASK:  rdata_nxt[`IRQ_MSB:0] = irq_mask_r;
      `ADDR_BASE_READ: rdata_nxt[`CNT_MSB:0] = base_sample_r;
      default:         unmapped_nxt = 1'b1;
    endcase
  end

  // Reads are captured in the setup cycle, so every answer takes one wait-free access phase.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= `RESET_WORD;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup_rd;
      if (setup_rd) begin
        o_prdata  <= i_pwrite ? `RESET_WORD : rdata_nxt;
        o_pslverr <= unmapped_nxt;
      end
    end
  end

  // ----------------------------------------
  // Software writes
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      endless_rx_r            <= 1'b0;
      endless_tx_r            <= 1'b0;
      payload_length_source_r <= 1'b0;
      pseudo_random_kind_r    <= 1'b0;
      payload_source_select_r <= 1'b0;
      test_payload_length_r   <= {(`RFT_LEN_MSB+1){1'b0}};
      table_prefetch_time_r   <= {(`PREF_MSB+1){1'b0}};
      coarse_target_value_r   <= {(`COARSE_MSB+1){1'b0}};
      slot_target_value_r     <= {(`CNT_MSB+1){1'b0}};
      rssi_sel_r              <= 1'b0;
      irq_mask_r              <= {(`IRQ_MSB+1){1'b0}};
    end else if (wr_en) begin
      case (i_paddr)
        `ADDR_RF_TEST: begin
          endless_rx_r            <= i_pwdata[`RFT_RX_BIT];
          endless_tx_r            <= i_pwdata[`RFT_TX_BIT];
          payload_length_source_r <= i_pwdata[`RFT_LSRC_BIT];
          pseudo_random_kind_r    <= i_pwdata[`RFT_PTYPE_BIT];
          payload_source_select_r <= i_pwdata[`RFT_PSRC_BIT];
          test_payload_length_r   <= i_pwdata[`RFT_LEN_MSB:0];
        end
        `ADDR_TIMING:    table_prefetch_time_r <= i_pwdata[`PREF_MSB:0];
        `ADDR_COARSE:    coarse_target_value_r <= i_pwdata[`COARSE_MSB:0];
        `ADDR_SLOT:      slot_target_value_r   <= i_pwdata[`CNT_MSB:0];
        `ADDR_CTRL2:     rssi_sel_r            <= i_pwdata[`RSSI_BIT];
        `ADDR_IRQ_MASK:  irq_mask_r            <= i_pwdata[`IRQ_MSB:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Base counter, targets and capture
  // ----------------------------------------
  slot_tick_counter #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_slot_counter (
    .i_core_clk    (i_core_clk),
    .i_rst         (i_rst),
    .o_count       (base_slot_counter),
    .o_cycles_left (cycles_left),
    .o_tick        (slot_tick)
  );

  // Targets are checked only on the cycle after the counter moves, so a match fires once.
  wire slot_hit   = slot_tick && (slot_target_value_r == base_slot_counter);
  wire coarse_hit = slot_tick
                 && (coarse_target_value_r == base_slot_counter[`GROSS_HI:`GROSS_LO])
                 && (base_slot_counter[`GROSS_SUB_MSB:0] == 4'h0);

  wire capture_wr = wr_en && (i_paddr == `ADDR_SAMPLE) && i_pwdata[`CAPT_BIT];

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      capture_r     <= 1'b0;
      base_sample_r <= {(`CNT_MSB+1){1'b0}};
    end else if (capture_r) begin
      base_sample_r <= base_slot_counter;
      capture_r     <= 1'b0;
    end else begin
      capture_r <= capture_wr;
    end
  end

  // Prefetch fires the given number of microseconds before each slot boundary.
  wire [`PRESC_MSB:0] pref_cycles = {9'h000, table_prefetch_time_r} * CYC_PER_US[`PRESC_MSB:0];

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_table_fetch <= 1'b0;
    end else begin
      o_table_fetch <= (cycles_left == pref_cycles);
    end
  end

  // ----------------------------------------
  // Low-power wakeup handling
  // ----------------------------------------
  wire lp_rise = lp_s2 && !lp_d;

  // The ack waits for two rising low-power clock edges after power-up, i.e. at least one full period.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      {wake_s1, wake_s2, wake_d} <= 3'h0;
      {pwr_s1, pwr_s2}           <= 2'h0;
      {lp_s1, lp_s2, lp_d}       <= 3'h0;
      lp_edges_r                 <= 2'h0;
      o_wakeup_ack               <= 1'b0;
    end else begin
      wake_s1 <= i_lowpower_wakeup_interrupt;
      wake_s2 <= wake_s1;
      wake_d  <= wake_s2;
      pwr_s1  <= i_radio_powered;
      pwr_s2  <= pwr_s1;
      lp_s1   <= i_lp_clk;
      lp_s2   <= lp_s1;
      lp_d    <= lp_s2;
      if (!wake_s2 || !pwr_s2) begin
        lp_edges_r   <= 2'h0;
        o_wakeup_ack <= 1'b0;
      end else if (lp_edges_r == `LP_EDGES_ACK) begin
        o_wakeup_ack <= 1'b1;
      end else if (lp_rise) begin
        lp_edges_r <= lp_edges_r + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  wire [`IRQ_MSB:0] irq_set = {wake_s2 && !wake_d, slot_hit, coarse_hit};
  wire [`IRQ_MSB:0] irq_clr = (wr_en && (i_paddr == `ADDR_IRQ_STAT)) ?
                              i_pwdata[`IRQ_MSB:0] : {(`IRQ_MSB+1){1'b0}};

  // A new event in the clearing cycle wins so that it is never lost.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_stat_r <= {(`IRQ_MSB+1){1'b0}};
      o_irq      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      o_irq      <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  // ----------------------------------------
  // Mode outputs
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_endless_receive        <= 1'b0;
      o_signal_strength_select <= 1'b0;
    end else begin
      o_endless_receive        <= endless_rx_r;
      o_signal_strength_select <= rssi_sel_r;
    end
  end

  // ----------------------------------------
  // Payload sequencer
  // ----------------------------------------
  wire [7:0] prbs9_byte;
  wire [7:0] prbs15_byte;
  reg  [1:0] pay_state_r;
  reg  [8:0] pay_count_r;
  wire       seed_gen = (pay_state_r == ST_IDLE) && i_payload_start;
  wire       step_gen = (pay_state_r == ST_LOAD);

  pn_sequence_gen #(
    .W    (9),
    .TAPS (`PRBS9_TAPS),
    .SEED (`PRBS9_SEED)
  ) u_prbs9 (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_seed     (seed_gen),
    .i_step     (step_gen),
    .o_byte     (prbs9_byte)
  );

  pn_sequence_gen #(
    .W    (15),
    .TAPS (`PRBS15_TAPS),
    .SEED (`PRBS15_SEED)
  ) u_prbs15 (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_seed     (seed_gen),
    .i_step     (step_gen),
    .o_byte     (prbs15_byte)
  );

  // Test length as length and payload source apply only in test mode, else the descriptor rules; endless memory transmit repeats at test length in any mode.
  wire       use_test_len = i_test_mode && payload_length_source_r;
  wire [8:0] pay_len      = use_test_len ? test_payload_length_r
                                         : {1'b0, i_descriptor_adv_length};
  wire       use_prbs     = i_test_mode && payload_source_select_r;
  wire [7:0] prbs_byte    = pseudo_random_kind_r ? prbs15_byte : prbs9_byte;
  wire [8:0] next_count   = pay_count_r + 1'b1;
  wire       repeat_mode  = endless_tx_r && !use_prbs;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      pay_state_r     <= ST_IDLE;
      pay_count_r     <= 9'h000;
      o_mem_index     <= 9'h000;
      o_payload_byte  <= 8'h00;
      o_payload_valid <= 1'b0;
      o_payload_last  <= 1'b0;
    end else begin
      case (pay_state_r)
        ST_IDLE: begin
          if (i_payload_start && (endless_tx_r || (pay_len != 9'h000))) begin
            pay_count_r <= 9'h000;
            o_mem_index <= 9'h000;
            pay_state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          o_payload_byte  <= use_prbs ? prbs_byte : i_mem_byte;
          o_payload_valid <= 1'b1;
          o_payload_last  <= !endless_tx_r && (next_count >= pay_len);
          pay_count_r     <= next_count;
          if (repeat_mode && (next_count >= test_payload_length_r)) begin
            pay_count_r <= 9'h000;
            o_mem_index <= 9'h000;
          end else begin
            o_mem_index <= next_count;
          end
          pay_state_r <= ST_HOLD;
        end
        ST_HOLD: begin
          if (i_payload_take) begin
            o_payload_valid <= 1'b0;
            o_payload_last  <= 1'b0;
            pay_state_r     <= o_payload_last ? ST_IDLE : ST_LOAD;
          end
        end
        default: begin
          pay_state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // radio_test_slot_regs

`default_nettype wire

// [core/radio_regs_consts.vh]
`ifndef RADIO_REGS_CONSTS_VH
`define RADIO_REGS_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_RF_TEST    32'h400000e0
`define ADDR_TIMING     32'h400000f0
`define ADDR_COARSE     32'h400000f4
`define ADDR_SLOT       32'h400000f8
`define ADDR_SAMPLE     32'h400000fc
`define ADDR_CTRL2      32'h40000200
`define ADDR_IRQ_STAT   32'h40000204
`define ADDR_IRQ_MASK   32'h40000208
`define ADDR_BASE_READ  32'h4000020c

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RESET_WORD      32'h00000000
`define RFT_RX_BIT      31
`define RFT_TX_BIT      15
`define RFT_LSRC_BIT    14
`define RFT_PTYPE_BIT   13
`define RFT_PSRC_BIT    12
`define RFT_LEN_MSB     8
`define PREF_MSB        7
`define COARSE_MSB      15
`define CNT_MSB         26
`define GROSS_HI        19
`define GROSS_LO        4
`define GROSS_SUB_MSB   3
`define CAPT_BIT        0
`define RSSI_BIT        21
`define WAKE_BIT        20
`define IRQ_COARSE_BIT  0
`define IRQ_SLOT_BIT    1
`define IRQ_WAKE_BIT    2
`define IRQ_MSB         2
`define PRESC_MSB       16

// ----------------------------------------
// Sequence generators
// ----------------------------------------
`define PRBS9_SEED      9'h1ff
`define PRBS9_TAPS      9'h110
`define PRBS15_SEED     15'h7fff
`define PRBS15_TAPS     15'h3803

// ----------------------------------------
// Timing
// ----------------------------------------
`define SLOT_TIME_NS    625000
`define CLK_PERIOD_NS   5
`define NS_PER_US       1000
`define LP_EDGES_ACK    2'h2

`endif

// [core/pn_sequence_gen.v]
`default_nettype none

module pn_sequence_gen #(
  parameter W    = 9,
  parameter TAPS = 9'h110,
  parameter SEED = 9'h1ff
) (
  // Clock and reset.
  input  wire         i_core_clk,
  input  wire         i_rst,
  // Control.
  input  wire         i_seed,
  input  wire         i_step,
  // Head byte, oldest bit in bit 0.
  output wire [7:0]   o_byte
);

  reg  [W-1:0] state_r;
  reg  [W-1:0] state_nxt;
  reg  [7:0]   byte_nxt;
  integer      k;

  // Eight shifts per byte are unrolled here so a byte costs one cycle.
  always @* begin
    state_nxt = state_r;
    byte_nxt  = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      byte_nxt[k] = state_nxt[W-1];
      state_nxt   = {state_nxt[W-2:0], ^(state_nxt & TAPS)};
    end
  end

  always @(posedge i_core_clk) begin
    if (i_rst || i_seed) begin
      state_r <= SEED;
    end else if (i_step) begin
      state_r <= state_nxt;
    end
  end

  assign o_byte = byte_nxt;

endmodule // pn_sequence_gen

`default_nettype wire

// [core/slot_tick_counter.v]
`default_nettype none
`include "radio_regs_consts.vh"

module slot_tick_counter #(
  parameter SLOT_CYCLES = `SLOT_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire                     i_core_clk,
  input  wire                     i_rst,
  // Counter state.
  output reg  [`CNT_MSB:0]        o_count,
  output reg  [`PRESC_MSB:0]      o_cycles_left,
  output reg                      o_tick
);

  localparam integer RELOAD = SLOT_CYCLES - 1;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_count       <= {(`CNT_MSB+1){1'b0}};
      o_cycles_left <= {(`PRESC_MSB+1){1'b0}};
      o_tick        <= 1'b0;
    end else if (o_cycles_left == {(`PRESC_MSB+1){1'b0}}) begin
      o_count       <= o_count + 1'b1;
      o_cycles_left <= RELOAD[`PRESC_MSB:0];
      o_tick        <= 1'b1;
    end else begin
      o_cycles_left <= o_cycles_left - 1'b1;
      o_tick        <= 1'b0;
    end
  end

endmodule // slot_tick_counter

`default_nettype wire

// [tb/radio_checker.sv]
`default_nettype none
`include "radio_regs_consts.vh"

module radio_checker #(
  parameter SLOT_CYCLES = 20
) (
  // Clock and reset.
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  // Register bus.
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  // Link-layer and power side.
  input wire logic        i_payload_take,
  input wire logic [7:0]  o_payload_byte,
  input wire logic        o_payload_valid,
  input wire logic        o_payload_last,
  input wire logic        o_endless_receive,
  input wire logic        o_table_fetch,
  input wire logic        o_signal_strength_select,
  input wire logic        i_radio_powered,
  input wire logic        o_wakeup_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Helpers
  // ----
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire wr_acc = i_psel && i_penable && o_pready && i_pwrite;
  wire rd_acc = i_psel && i_penable && o_pready && !i_pwrite;
  logic [31:0] gap_r;
  logic        seen_r;
  // A new prefetch value moves the instant, so the spacing is only judged between
  // two pulses that share one setting.
  always @(posedge i_core_clk) begin
    if (i_rst || (wr_acc && i_paddr == `ADDR_TIMING)) begin
      gap_r <= 32'h0;
      seen_r <= 1'b0;
    end else if (o_table_fetch) begin
      gap_r <= 32'h0;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 32'h1;
    end
  end
  // ----
  // Assertions
  // ----
  AST_ENDLESS_RX: assert property (
    wr_acc && i_paddr == `ADDR_RF_TEST |-> ##2 o_endless_receive == $past(i_pwdata[31], 2))
    else $error("endless receive output differs from its written bit");
  AST_STRENGTH: assert property (
    wr_acc && i_paddr == `ADDR_CTRL2 |-> ##2 o_signal_strength_select == $past(i_pwdata[21], 2))
    else $error("strength select output differs from its written bit");
  AST_RESERVED_RF: assert property (
    rd_acc && i_paddr == `ADDR_RF_TEST |-> o_prdata[30:16] == 15'h0 && o_prdata[11:9] == 3'h0)
    else $error("reserved test control bits read nonzero");
  AST_SAMPLE_READ: assert property (
    rd_acc && i_paddr == `ADDR_SAMPLE |-> o_prdata[31:1] == 31'h0)
    else $error("reserved sample trigger bits read nonzero");
  AST_FETCH_GAP: assert property (
    o_table_fetch && seen_r |-> gap_r == SLOT_CYCLES - 1)
    else $error("prefetch pulses not one slot apart");
  AST_LAST: assert property (
    o_payload_last |-> o_payload_valid)
    else $error("last flag without valid byte");
  AST_HOLD: assert property (
    o_payload_valid && !i_payload_take |=> o_payload_valid && $stable(o_payload_byte))
    else $error("payload byte dropped before it was taken");
  AST_TAKE: assert property (
    o_payload_valid && i_payload_take && !o_payload_last |=> !o_payload_valid ##1 o_payload_valid)
    else $error("next payload byte not offered two cycles after take");
  AST_WAKE_OFF: assert property (
    !i_radio_powered [*5] |-> !o_wakeup_ack)
    else $error("wakeup acknowledged while radio unpowered");
endmodule // radio_checker

`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
`include "radio_regs_consts.vh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Signals
  // ----
  logic        i_core_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, ev;
  logic [31:0] i_paddr, i_pwdata, o_prdata, rv, c;
  logic        i_test_mode, i_payload_start, i_payload_take, o_payload_valid;
  logic [7:0]  i_descriptor_adv_length, i_mem_byte, o_payload_byte;
  logic [8:0]  o_mem_index;
  logic        o_payload_last, o_endless_receive, o_table_fetch, o_signal_strength_select;
  logic        i_lowpower_wakeup_interrupt, i_radio_powered, i_lp_clk, o_wakeup_ack, o_irq;
  int          n_mismatch, comparisons, n, i;
  logic [31:0] ad [6];
  logic [31:0] rm [6];
  // Each memory byte differs from its neighbours, so a wrong index shows.
  assign i_mem_byte = o_mem_index[7:0] ^ 8'ha5;

  radio_test_slot_regs #(.SLOT_CYCLES(20)) radio_test_slot_regs_i (
    .i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_test_mode, .i_descriptor_adv_length,
    .i_payload_start, .i_payload_take, .i_mem_byte, .o_mem_index, .o_payload_byte,
    .o_payload_valid, .o_payload_last, .o_endless_receive, .o_table_fetch,
    .o_signal_strength_select, .i_lowpower_wakeup_interrupt, .i_radio_powered,
    .i_lp_clk, .o_wakeup_ack, .o_irq);

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (k >= 20) n_mismatch++;
    rv = o_prdata;
    ev = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, rv & m);
  endtask
  task automatic cap();
    wr(`ADDR_SAMPLE, 32'h1);
    repeat (3) @(posedge i_core_clk);
    apb(1'b0, `ADDR_BASE_READ, 32'h0);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic lp(input int t);
    repeat (t) begin
      repeat (3) @(posedge i_core_clk);
      i_lp_clk <= ~i_lp_clk;
    end
  endtask
  task automatic start();
    @(posedge i_core_clk);
    i_payload_start <= 1'b1;
    @(posedge i_core_clk);
    i_payload_start <= 1'b0;
  endtask
  task automatic pbyte(input logic [7:0] e, input logic [7:0] m, input logic l);
    int k;
    k = 0;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (o_payload_valid !== 1'b1 && k < 20);
    chk("payload", {22'h0, 1'b1, l, e & m},
        {22'h0, o_payload_valid, o_payload_last, o_payload_byte & m});
    i_payload_take <= 1'b1;
    @(posedge i_core_clk);
    i_payload_take <= 1'b0;
  endtask
  task automatic tgt(input logic [31:0] a, input logic [31:0] m, input logic [31:0] t,
                     input logic [31:0] e);
    int k;
    wr(`ADDR_IRQ_STAT, 32'h7);
    wr(`ADDR_IRQ_MASK, 32'h0);
    wr(a, t);
    k = 0;
    do begin
      apb(1'b0, `ADDR_IRQ_STAT, 32'h0);
      k++;
    end while ((rv & m) !== m && k < 400);
    cap();
    chk("count at event", e, rv);
    chk("masked irq", 32'h0, {31'h0, o_irq});
    wr(`ADDR_IRQ_MASK, m);
    repeat (3) @(posedge i_core_clk);
    chk("unmasked irq", 32'h1, {31'h0, o_irq});
    // Moving the target first keeps a still-matching count from setting it again.
    wr(a, t ^ 32'h100);
    wr(`ADDR_IRQ_STAT, m);
    repeat (3) @(posedge i_core_clk);
    chk("cleared irq", 32'h0, {31'h0, o_irq});
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (30000) @(posedge i_core_clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    ad = '{`ADDR_RF_TEST, `ADDR_TIMING, `ADDR_COARSE, `ADDR_SLOT, `ADDR_SAMPLE, `ADDR_CTRL2};
    rm = '{32'h8000f1ff, 32'hff, 32'hffff, 32'h07ffffff, 32'h0, 32'h00200000};
    {i_psel, i_penable, i_pwrite, i_test_mode, i_payload_start, i_payload_take} = 6'h0;
    {i_lowpower_wakeup_interrupt, i_radio_powered, i_lp_clk} = 3'h0;
    {i_paddr, i_pwdata, i_descriptor_adv_length} = 72'h0;
    {n_mismatch, comparisons} = 64'h0;
    i_rst = 1'b1;
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    for (i = 0; i < 6; i++) rd(ad[i], 32'hffffffff, 32'h0);
    for (i = 0; i < 6; i++) begin
      wr(ad[i], 32'hffffffff);
      rd(ad[i], 32'hffffffff, rm[i]);
    end
    chk("endless receive", 32'h1, {31'h0, o_endless_receive});
    chk("strength select", 32'h1, {31'h0, o_signal_strength_select});
    wr(`ADDR_RF_TEST, 32'h0);
    wr(`ADDR_CTRL2, 32'h0);
    repeat (2) @(posedge i_core_clk);
    chk("endless receive", 32'h0, {31'h0, o_endless_receive});
    chk("strength select", 32'h0, {31'h0, o_signal_strength_select});
    apb(1'b0, 32'h40000100, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, ev});
    chk("unmapped data", 32'h0, rv);
    done("registers");
    for (i = 0; i < 2; i++) begin
      wr(`ADDR_TIMING, (i == 0) ? 32'h0 : 32'hff);
      @(posedge i_core_clk);
      n = 0;
      repeat (100) begin
        @(posedge i_core_clk);
        n += (o_table_fetch === 1'b1);
      end
      chk("prefetch pulses", (i == 0) ? 32'h5 : 32'h0, n);
    end
    cap();
    c = rv;
    repeat (191) @(posedge i_core_clk);
    cap();
    chk("slots in 200 cycles", c + 32'ha, rv);
    cap();
    c = rv;
    tgt(`ADDR_SLOT, 32'h2, c + 32'h3, c + 32'h3);
    cap();
    c = rv;
    tgt(`ADDR_COARSE, 32'h1, {16'h0, c[19:4] + 16'h2}, {12'h0, c[19:4] + 16'h2, 4'h0});
    done("timers");
    i_lowpower_wakeup_interrupt <= 1'b1;
    lp(6);
    chk("ack unpowered", 32'h0, {31'h0, o_wakeup_ack});
    rd(`ADDR_CTRL2, 32'h00100000, 32'h00100000);
    i_radio_powered <= 1'b1;
    lp(6);
    chk("ack powered", 32'h1, {31'h0, o_wakeup_ack});
    rd(`ADDR_IRQ_STAT, 32'h4, 32'h4);
    i_lowpower_wakeup_interrupt <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, `ADDR_CTRL2, 32'h0);
      n++;
    end while (rv[20] !== 1'b0 && n < 20);
    chk("wakeup status", 32'h0, {31'h0, rv[20]});
    chk("ack released", 32'h0, {31'h0, o_wakeup_ack});
    done("wakeup");
    i_test_mode <= 1'b1;
    wr(`ADDR_RF_TEST, 32'h00005004);
    start();
    pbyte(8'hff, 8'hff, 1'b0);
    pbyte(8'hc1, 8'hff, 1'b0);
    pbyte(8'hfb, 8'hff, 1'b0);
    pbyte(8'he8, 8'hff, 1'b1);
    wr(`ADDR_RF_TEST, 32'h00007002);
    start();
    pbyte(8'hff, 8'hff, 1'b0);
    pbyte(8'hff, 8'hff, 1'b1);
    wr(`ADDR_RF_TEST, 32'h00004003);
    start();
    for (i = 0; i < 3; i++) pbyte(8'ha5 ^ 8'(i), 8'hff, i == 2);
    i_test_mode <= 1'b0;
    i_descriptor_adv_length <= 8'h2;
    start();
    for (i = 0; i < 2; i++) pbyte(8'ha5 ^ 8'(i), 8'hff, i == 1);
    i_test_mode <= 1'b1;
    wr(`ADDR_RF_TEST, 32'h0000c003);
    start();
    for (i = 0; i < 7; i++) pbyte(8'ha5 ^ 8'(i % 3), 8'hff, 1'b0);
    done("payload");
    finish_test();
  end
endmodule // testbench

bind radio_test_slot_regs radio_checker #(.SLOT_CYCLES(SLOT_CYCLES)) radio_checker_i (
  .i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
  .o_pready, .i_payload_take, .o_payload_byte, .o_payload_valid, .o_payload_last,
  .o_endless_receive, .o_table_fetch, .o_signal_strength_select, .i_radio_powered,
  .o_wakeup_ack);

`default_nettype wire
